// >>> lfs_pkg.sv
// Purpose: shared constants and carrier types for the LED fault supervisor
// Assumes: 40 MHz system clock
// Notes: analog comparators arrive as digital fault inputs
package lfs_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int NUM_STRINGS = 4;
  localparam int CLEAR_TIME_MS = 16;
  localparam int CLEAR_CYCLES = CLEAR_TIME_MS * (CLK_HZ / 1000);
  localparam int PSC_DETECT_NS = 5500;
  localparam int PSC_DETECT_CYCLES = (PSC_DETECT_NS * (CLK_HZ / 1000000)
    + 999) / 1000;
  localparam int CLKDIV_HALF = 10;
  localparam logic [1:0] RST_ACTIONS = 2'h0;

  // Raw fault comparator results, all active high
  typedef struct packed {
    logic sw_lim1;
    logic sw_lim2;
    logic sense_trip;
    logic sw_ovp2;
    logic led_current_set_pin_short;
    logic frequency_set_pin_short;
    logic ovp;
    logic ovp_release;
    logic out_uvp;
    logic over_temp;
    logic hyst_cool;
  } lfs_faults_t;

  // Power stage gating decisions
  typedef struct packed {
    logic boost_en;
    logic disconnect_on;
    logic softstart_run;
  } lfs_actions_t;

  typedef enum logic [1:0] {
    LFS_OFF = 2'b00,
    LFS_SOFTSTART = 2'b01,
    LFS_RUN = 2'b10,
    LFS_LATCHED = 2'b11
  } lfs_state_t;
endpackage

// >>> lfs_sync.sv
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: single clock domain
// Notes: first stage read only by the second
`timescale 1ns/10ps
`default_nettype none
module lfs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta <= '0;
      o_q <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> lfs_low_timer.sv
// Purpose: measures a continuous low level on a pin
// Assumes: input already synchronised
// Notes: restarts from zero on any high sample
`timescale 1ns/10ps
`default_nettype none
module lfs_low_timer #(
  parameter int LIMIT = lfs_pkg::CLEAR_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_arm,
  input wire logic i_level,
  output logic o_expired
);
  logic [31:0] count;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      count <= 32'h0;
      o_expired <= 1'b0;
    end
    else if (!i_arm || i_level)
    begin
      count <= 32'h0;
      o_expired <= 1'b0;
    end
    else if (count < LIMIT[31:0])
    begin
      count <= count + 32'h1;
      o_expired <= 1'b0;
    end
    else
      o_expired <= 1'b1;
  end
endmodule
`default_nettype wire

// >>> lfs_supervisor.sv
// Purpose: fault supervisor for a four string boost LED driver
// Assumes: comparator outputs and pins asynchronous, 40 MHz clock
// Notes: sinks, boost gate, disconnect and flag are registered
// Notes on behaviour
// - Cycle limit truncates one on-time only
// - Secondary switch limit latches everything off
// - Input sense trip latches everything off
// - Switch node overvoltage latches everything off
// - Grounded sink pin halts soft-start
// - Open string disabled after output rise
// - Current-set short stops boost, sinks; flag
// - Frequency-set short shuts all; soft-start restart
// - Overvoltage stops boost until 97% release
// - Output undervoltage stops boost, sinks; flag
// - Partial short disables only that string
// - Short on-time hides partial short detection
// - Over-temperature shuts all until hysteresis
// - Input lockout shuts all, clears latches
// - Only three faults latch
// - Enable or dimming low 16 ms clears
// - Dimming-low clearing keeps clock output
// - Persisting fault re-trips after clearing
// - Detection active in every state except per-string checks
`timescale 1ns/10ps
`default_nettype none
module lfs_supervisor #(
  parameter int CLEAR_LIMIT = lfs_pkg::CLEAR_CYCLES,
  parameter int NSTR = lfs_pkg::NUM_STRINGS
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_enable,
  input wire logic i_dim_pwm,
  input wire logic i_input_undervoltage_lockout,
  input wire lfs_pkg::lfs_faults_t i_faults,
  input wire logic [NSTR-1:0] i_string_sink_pin_gnd,
  input wire logic [NSTR-1:0] i_string_lacks_current,
  input wire logic [NSTR-1:0] i_string_partial_short,
  input wire logic [NSTR-1:0] i_string_low_1v2,
  input wire logic i_ovp_reached,
  output logic o_boost_gate_en,
  output logic o_boost_on_truncate,
  output logic o_disconnect_on,
  output logic [NSTR-1:0] o_sink_en,
  output logic o_fault_flag,
  output logic o_raise_output,
  output logic o_switching_clock_output,
  output lfs_pkg::lfs_state_t o_state
);
  lfs_pkg::lfs_faults_t flt;
  logic en_s, pwm_s, input_undervoltage_lockout_s, ovp_top_s;
  logic [NSTR-1:0] gnd_s, lack_s, psc_s, low_s;
  logic en_clear, pwm_clear, clear_latch;
  logic latch_any;
  logic ovp_hold, hot, frequency_set_pin_seen, startup_check;
  logic [NSTR-1:0] str_open, str_short;
  logic [7:0] pwm_on_cnt;
  logic [7:0] div_cnt;
  lfs_pkg::lfs_state_t state, next_state;

  lfs_sync #(.WIDTH($bits(lfs_pkg::lfs_faults_t))) u_sync_flt (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_d(i_faults),
    .o_q(flt)
  );

  lfs_sync #(.WIDTH(4 + 4 * NSTR)) u_sync_pins (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_d({i_enable, i_dim_pwm, i_input_undervoltage_lockout, i_ovp_reached,
      i_string_sink_pin_gnd, i_string_lacks_current,
      i_string_partial_short, i_string_low_1v2}),
    .o_q({en_s, pwm_s, input_undervoltage_lockout_s, ovp_top_s, gnd_s, lack_s, psc_s, low_s})
  );

  // Enable low for the clearing interval
  lfs_low_timer #(.LIMIT(CLEAR_LIMIT)) u_en_timer (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_arm(1'b1),
    .i_level(en_s),
    .o_expired(en_clear)
  );

  // Dimming low with enable high; clock keeps running
  lfs_low_timer #(.LIMIT(CLEAR_LIMIT)) u_pwm_timer (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_arm(en_s),
    .i_level(pwm_s),
    .o_expired(pwm_clear)
  );

  assign clear_latch = input_undervoltage_lockout_s || en_clear || pwm_clear;

  // Only three latching sources; set wins so a live fault re-trips
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      latch_any <= 1'b0;
    else if (flt.sw_lim2 || flt.sense_trip || flt.sw_ovp2)
      latch_any <= 1'b1;
    else if (clear_latch)
      latch_any <= 1'b0;
  end

  // Overvoltage hysteresis: hold until output drains to release level
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      ovp_hold <= 1'b0;
    else if (flt.ovp)
      ovp_hold <= 1'b1;
    else if (flt.ovp_release)
      ovp_hold <= 1'b0;
  end

  // Thermal hysteresis
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      hot <= 1'b0;
    else if (flt.over_temp)
      hot <= 1'b1;
    else if (flt.hyst_cool)
      hot <= 1'b0;
  end

  // On-time counter gates partial-short detection
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pwm_on_cnt <= 8'h00;
    else if (!pwm_s)
      pwm_on_cnt <= 8'h00;
    else if (pwm_on_cnt < 8'(lfs_pkg::PSC_DETECT_CYCLES))
      pwm_on_cnt <= pwm_on_cnt + 8'h01;
  end

  // Armed by dimming level, not edge: pin may already be high at restart
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      startup_check <= 1'b0;
    else if (state != lfs_pkg::LFS_SOFTSTART)
      startup_check <= 1'b0;
    else if (pwm_s)
      startup_check <= 1'b1;
  end

  // Frequency-set short forces a fresh soft-start
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      frequency_set_pin_seen <= 1'b0;
    else
      frequency_set_pin_seen <= flt.frequency_set_pin_short;
  end

  always_comb
  begin
    next_state = state;
    case (state)
      lfs_pkg::LFS_OFF:
        if (en_s && !input_undervoltage_lockout_s)
          next_state = lfs_pkg::LFS_SOFTSTART;
      lfs_pkg::LFS_SOFTSTART:
        if (startup_check && gnd_s == '0 && pwm_s)
          next_state = lfs_pkg::LFS_RUN;
      lfs_pkg::LFS_RUN:
        next_state = lfs_pkg::LFS_RUN;
      lfs_pkg::LFS_LATCHED:
        if (!latch_any)
          next_state = lfs_pkg::LFS_OFF;
      default:
        next_state = lfs_pkg::LFS_OFF;
    endcase
    // Detection overrides every state and transition
    if (latch_any)
      next_state = lfs_pkg::LFS_LATCHED;
    else if (!en_s || input_undervoltage_lockout_s || hot || frequency_set_pin_seen)
      next_state = lfs_pkg::LFS_OFF;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      state <= lfs_pkg::LFS_OFF;
    else
      state <= next_state;
  end

  // Per-string disables: open and partial short, auto-restart
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      str_open <= '0;
      str_short <= '0;
    end
    else if (state != lfs_pkg::LFS_RUN)
    begin
      str_open <= '0;
      str_short <= '0;
    end
    else
    begin
      for (int i = 0; i < NSTR; i++)
      begin
        if (ovp_top_s && lack_s[i])
          str_open[i] <= 1'b1;
        if (pwm_on_cnt >= 8'(lfs_pkg::PSC_DETECT_CYCLES) && psc_s[i]
            && ((low_s & ~(NSTR'(1) << i)) != '0) && !str_open[i])
          str_short[i] <= 1'b1;
      end
    end
  end

  assign o_raise_output = (state == lfs_pkg::LFS_RUN)
    && ((lack_s & ~str_open) != '0) && !ovp_top_s;

  // Output gating, evaluated every cycle
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_boost_gate_en <= 1'b0;
      o_disconnect_on <= 1'b0;
      o_sink_en <= '0;
      o_fault_flag <= 1'b0;
      o_boost_on_truncate <= 1'b0;
    end
    else
    begin
      o_boost_on_truncate <= flt.sw_lim1;
      o_disconnect_on <= (state == lfs_pkg::LFS_SOFTSTART
        || state == lfs_pkg::LFS_RUN) && !latch_any
        && !flt.frequency_set_pin_short && !hot && !input_undervoltage_lockout_s;
      o_boost_gate_en <= state == lfs_pkg::LFS_RUN && !latch_any
        && !flt.led_current_set_pin_short && !flt.frequency_set_pin_short && !flt.out_uvp
        && !ovp_hold && !hot && !input_undervoltage_lockout_s;
      if (state == lfs_pkg::LFS_RUN && !latch_any && !flt.led_current_set_pin_short
          && !flt.frequency_set_pin_short && !flt.out_uvp && !hot && !input_undervoltage_lockout_s)
        o_sink_en <= ~(str_open | str_short);
      else
        o_sink_en <= '0;
      o_fault_flag <= latch_any || flt.led_current_set_pin_short || flt.frequency_set_pin_short
        || flt.out_uvp || hot;
    end
  end

  // Clock output runs while enable is high, held low otherwise; unaffected by dimming-low clearing
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      div_cnt <= 8'h00;
      o_switching_clock_output <= 1'b0;
    end
    else if (!en_s)
    begin
      div_cnt <= 8'h00;
      o_switching_clock_output <= 1'b0;
    end
    else if (div_cnt == 8'(lfs_pkg::CLKDIV_HALF - 1))
    begin
      div_cnt <= 8'h00;
      o_switching_clock_output <= !o_switching_clock_output;
    end
    else
      div_cnt <= div_cnt + 8'h01;
  end

  assign o_state = state;

  property p_latch_off;
    @(posedge i_clk) disable iff (!i_arst_n)
    flt.sw_lim2 |=> ##1 (!o_boost_gate_en && !o_disconnect_on
      && o_sink_en == '0 && o_fault_flag);
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("latch not off");

  property p_sense;
    @(posedge i_clk) disable iff (!i_arst_n)
    flt.sense_trip |=> latch_any;
  endproperty
  a_sense: assert property (p_sense) else $error("sense no latch");

  property p_retrip;
    @(posedge i_clk) disable iff (!i_arst_n)
    (flt.sw_ovp2 && clear_latch) |=> latch_any;
  endproperty
  a_retrip: assert property (p_retrip) else $error("no re-trip");

  property p_ovp;
    @(posedge i_clk) disable iff (!i_arst_n)
    ovp_hold |=> !o_boost_gate_en;
  endproperty
  a_ovp: assert property (p_ovp) else $error("boost during ovp");

  property p_led_current_set_pin;
    @(posedge i_clk) disable iff (!i_arst_n)
    (flt.led_current_set_pin_short && !latch_any && state == lfs_pkg::LFS_RUN
      && !hot && !input_undervoltage_lockout_s && !flt.frequency_set_pin_short)
    |=> (o_disconnect_on && o_sink_en == '0 && o_fault_flag);
  endproperty
  a_led_current_set_pin: assert property (p_led_current_set_pin) else $error("led_current_set_pin action");

  property p_clear;
    @(posedge i_clk) disable iff (!i_arst_n)
    (latch_any && $rose(en_clear) && !flt.sw_lim2 && !flt.sense_trip
      && !flt.sw_ovp2) |=> !latch_any;
  endproperty
  a_clear: assert property (p_clear) else $error("no clear");

  property p_input_undervoltage_lockout;
    @(posedge i_clk) disable iff (!i_arst_n)
    input_undervoltage_lockout_s |=> (!o_disconnect_on && !o_boost_gate_en);
  endproperty
  a_input_undervoltage_lockout: assert property (p_input_undervoltage_lockout) else $error("input_undervoltage_lockout on");

  property p_cbc;
    @(posedge i_clk) disable iff (!i_arst_n)
    flt.sw_lim1 |=> o_boost_on_truncate;
  endproperty
  a_cbc: assert property (p_cbc) else $error("no truncate");

  c_latch: cover property (@(posedge i_clk) state == lfs_pkg::LFS_LATCHED);
  c_run: cover property (@(posedge i_clk) state == lfs_pkg::LFS_RUN);
  c_clear: cover property (@(posedge i_clk) pwm_clear && en_s);
endmodule
`default_nettype wire

// >>> lfs_host.sv
// Purpose: host model that drives the enable and dimming pins
// Assumes: pins change 2 ns after a rising clock edge
// Notes: clear hold length chosen by caller, short or long
`timescale 1ns/10ps
`default_nettype none
module lfs_host (
  input wire logic i_clk,
  output logic o_enable,
  output logic o_dim_pwm
);
  initial
  begin
    o_enable = 1'b0;
    o_dim_pwm = 1'b0;
  end

  task automatic set_pins(input logic en, input logic dim);
    @(posedge i_clk);
    #2;
    o_enable = en;
    o_dim_pwm = dim;
  endtask

  // Pull one pin low for n+1 cycles, then restore both pins high
  task automatic hold_low(input logic use_en, input int n);
    logic d;
    d = o_dim_pwm;
    set_pins(!use_en, use_en & d);
    repeat (n) @(posedge i_clk);
    set_pins(1'b1, 1'b1);
  endtask
endmodule
`default_nettype wire

// >>> lfs_tb.sv
// Purpose: self-checking bench for the LED fault supervisor
// Assumes: clearing limit shortened to 20 cycles
// Notes: latencies judged after settled windows of 8 cycles
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int LIM = 20;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic input_undervoltage_lockout, ovp_hit, en, dim;
  lfs_pkg::lfs_faults_t faults;
  logic [3:0] gnd, lacks, psh, low12, sink;
  logic boost, trunc, disc, flag, raise, clko, seen;
  lfs_pkg::lfs_state_t state;
  int num_errors = 0;
  int cmp_count = 0;
  int seed = 32'h54BA;
  int k, j, toggles;
  logic [10:0] fv [8] = '{11'h209, 11'h109, 11'h089, 11'h049, 11'h029,
    11'h011, 11'h00D, 11'h00A};
  logic [3:0] ex [8] = '{4'h1, 4'h1, 4'h1, 4'h5, 4'h1, 4'h6, 4'h5, 4'h1};

  always #12.5 clk = ~clk;
  always @(clko) toggles++;

  lfs_host u_host (.i_clk(clk), .o_enable(en), .o_dim_pwm(dim));

  lfs_supervisor #(.CLEAR_LIMIT(LIM)) u_dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_enable(en), .i_dim_pwm(dim),
    .i_input_undervoltage_lockout(input_undervoltage_lockout), .i_faults(faults),
    .i_string_sink_pin_gnd(gnd), .i_string_lacks_current(lacks),
    .i_string_partial_short(psh), .i_string_low_1v2(low12),
    .i_ovp_reached(ovp_hit), .o_boost_gate_en(boost),
    .o_boost_on_truncate(trunc), .o_disconnect_on(disc), .o_sink_en(sink),
    .o_fault_flag(flag), .o_raise_output(raise),
    .o_switching_clock_output(clko), .o_state(state)
  );

  task automatic end_of_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask

  // Step to 2 ns past the n-th coming edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic wait_run;
    int n;
    n = 0;
    while (state !== lfs_pkg::LFS_RUN && n < 4000)
    begin
      cyc(1);
      n++;
    end
    chk(state === lfs_pkg::LFS_RUN, "no run state");
  endtask

  initial
  begin
    #2ms;
    num_errors++;
    end_of_test();
  end

  initial
  begin
    faults = 11'h009;
    {input_undervoltage_lockout, ovp_hit} = 2'h0;
    {gnd, lacks, psh, low12} = 16'h0;
    k = {$random(seed)} % 4;
    cyc(2);
    arst_n = 1'b1;
    gnd[k] = 1'b1;
    u_host.set_pins(1'b1, 1'b1);
    cyc(40);
    chk(state !== lfs_pkg::LFS_RUN, "start not halted");
    chk({boost, disc, sink, flag} === 7'h20, "ground outputs");
    gnd = 4'h0;
    wait_run();
    for (int i = 0; i < 8; i++)
    begin
      faults = lfs_pkg::lfs_faults_t'(fv[i]);
      cyc(8);
      chk({boost, disc, sink, flag} === {ex[i][3:2], {4{ex[i][1]}},
        ex[i][0]}, "fault outputs");
      if (i == 0 || i == 2)
      begin
        u_host.hold_low(1'b0, LIM + 10);
        cyc(8);
        chk(state === lfs_pkg::LFS_LATCHED, "no retrip");
      end
      faults = 11'h009;
      cyc(8);
      if (i < 3)
      begin
        chk(state === lfs_pkg::LFS_LATCHED && flag === 1'b1, "latch");
        if (i == 0)
        begin
          u_host.hold_low(1'b0, LIM - 5);
          u_host.hold_low(1'b0, LIM - 5);
          cyc(8);
          chk(state === lfs_pkg::LFS_LATCHED, "early clear");
        end
        toggles = 0;
        u_host.hold_low(i == 1, LIM + 10);
        if (i != 1)
          chk(toggles > 2, "clock output stopped");
      end
      wait_run();
      chk(flag === 1'b0, "flag stuck");
    end
    faults = 11'h409;
    cyc(1);
    faults = 11'h009;
    seen = 1'b0;
    repeat (6)
    begin
      cyc(1);
      seen = seen | trunc;
    end
    chk(seen && {disc, sink, flag} === 6'h3E, "cycle limit");
    lacks[k] = 1'b1;
    cyc(8);
    chk(raise === 1'b1, "no raise");
    ovp_hit = 1'b1;
    cyc(8);
    chk(sink === ~(4'h1 << k) && {boost, flag} === 2'h2, "open");
    {lacks, ovp_hit} = 5'h0;
    j = (k + 2) % 4;
    psh[j] = 1'b1;
    low12[(j + 1) % 4] = 1'b1;
    // Dimming on-times kept below the detection time
    repeat (3)
    begin
      u_host.hold_low(1'b0, 2);
      cyc(40 + {$random(seed)} % 150);
      chk(sink === ~(4'h1 << k), "short on-time");
    end
    cyc(300);
    chk(sink === ~((4'h1 << k) | (4'h1 << j)) && {boost, flag} === 2'h2,
      "partial short");
    {psh, low12} = 8'h0;
    faults = 11'h089;
    cyc(8);
    faults = 11'h009;
    input_undervoltage_lockout = 1'b1;
    cyc(8);
    chk({boost, disc, sink, flag} === 7'h0, "lockout outputs");
    input_undervoltage_lockout = 1'b0;
    wait_run();
    end_of_test();
  end
endmodule
`default_nettype wire
